// ===== spi_buffered_control_status.sv
// Byte-wide SPI master/slave unit with buffered and unbuffered modes
`default_nettype none

module spi_buffered_control_status #(
  parameter logic [7:0] SCK_HALF = 8'(spi_pkg::SCK_HALF_CYCLES)
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic IRQ,
  input wire logic IRQ_ACK,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE,
  input wire logic SS_N
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  spi_pkg::state_t s_q;
  spi_pkg::state_t s_d;
  logic done;
  logic start;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic sample;
    logic setup;
    logic leading;
    logic in_bit;
    logic direct;
    logic [7:0] byte_in;
    sample = 1'b0;
    setup = 1'b0;
    leading = 1'b0;
    in_bit = 1'b0;
    direct = 1'b0;
    byte_in = 8'h00;
    s_d = s_q;
    done = 1'b0;
    start = 1'b0;

    // Pin synchronisers, filtered once stages two and three agree
    s_d.ss_s = {s_q.ss_s[1:0], SS_N};
    s_d.sck_s = {s_q.sck_s[1:0], SCK_I};
    s_d.mosi_s = {s_q.mosi_s[1:0], MOSI_I};
    s_d.miso_s = {s_q.miso_s[1:0], MISO_I};
    if (s_q.ss_s[2] == s_q.ss_s[1]) s_d.ss_f = s_q.ss_s[2];
    if (s_q.sck_s[2] == s_q.sck_s[1]) s_d.sck_f = s_q.sck_s[2];
    if (s_q.mosi_s[2] == s_q.mosi_s[1]) s_d.mosi_f = s_q.mosi_s[2];
    if (s_q.miso_s[2] == s_q.miso_s[1]) s_d.miso_f = s_q.miso_s[2];

    // Control, enable and flag register writes
    if (WR) begin
      case (ADDR)
        spi_pkg::ADDR_CTRL_A: begin
          s_d.enable = WDATA[spi_pkg::CA_ENABLE];
          s_d.master = WDATA[spi_pkg::CA_MASTER];
        end
        spi_pkg::ADDR_CTRL_B: begin
          s_d.buffer_enable = WDATA[spi_pkg::CB_BUFFER_ENABLE];
          s_d.wait_for_receive = WDATA[spi_pkg::CB_WAIT_FOR_RECEIVE];
          s_d.slave_select_disable = WDATA[spi_pkg::CB_SLAVE_SELECT_DISABLE];
          s_d.mode = WDATA[spi_pkg::CB_MODE_LO +: 2];
        end
        spi_pkg::ADDR_IRQ_EN: begin
          s_d.rx_complete_irq_enable = WDATA[spi_pkg::IE_RX_COMPLETE];
          s_d.tx_complete_irq_enable = WDATA[spi_pkg::IE_TX_COMPLETE];
          s_d.data_empty_irq_enable = WDATA[spi_pkg::IE_DATA_EMPTY];
          s_d.select_trigger_irq_enable = WDATA[spi_pkg::IE_SELECT_TRIGGER];
          s_d.single_irq_enable = WDATA[spi_pkg::IE_SINGLE];
        end
        spi_pkg::ADDR_FLAGS: begin
          // Write-one clears in buffered mode; data empty and overflow bits ignored
          if (s_q.buffer_enable) begin
            if (WDATA[spi_pkg::FL_RX_COMPLETE]) s_d.rx_complete_flag = 1'b0;
            if (WDATA[spi_pkg::FL_TX_COMPLETE]) s_d.tx_complete_flag = 1'b0;
            if (WDATA[spi_pkg::FL_SELECT_TRIGGER]) s_d.select_trigger_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Two-step clear of done and collision flags
    if (RD && ADDR == spi_pkg::ADDR_FLAGS && !s_q.buffer_enable &&
        (s_q.done_flag || s_q.write_collision_flag)) begin
      s_d.clear_armed = 1'b1;
    end
    if ((WR || RD) && ADDR == spi_pkg::ADDR_DATA && s_q.clear_armed) begin
      s_d.done_flag = 1'b0;
      s_d.write_collision_flag = 1'b0;
      s_d.clear_armed = 1'b0;
    end
    if (IRQ_ACK && !s_q.buffer_enable) s_d.done_flag = 1'b0;

    // Buffered data read pops the receive pair
    if (RD && ADDR == spi_pkg::ADDR_DATA && s_q.buffer_enable) begin
      s_d.rx_second = s_q.rx_first;
      s_d.rx_second_valid = s_q.rx_first_valid;
      s_d.rx_first_valid = 1'b0;
      s_d.rx_overflow_flag = 1'b0;
      if (!s_q.rx_first_valid) s_d.rx_complete_flag = 1'b0;
    end

    // Shift engine
    // Filtered level as it settles this cycle, so a bit set up half a period ago is seen
    in_bit = s_q.master ? s_d.miso_f : s_d.mosi_f;
    unique case (s_q.ph)
      spi_pkg::PH_IDLE: begin
        s_d.div = 8'h00;
        s_d.edges = 5'h00;
        s_d.bits = 3'h0;
        if (s_q.master) s_d.sck = s_q.mode[1];
        if (s_q.enable && !s_q.master && !s_q.ss_f) start = 1'b1;
      end
      spi_pkg::PH_SHIFT: begin
        if (s_q.master) begin
          if (s_q.div == SCK_HALF - 8'h01) begin
            s_d.div = 8'h00;
            s_d.sck = ~s_q.sck;
            s_d.edges = s_q.edges + 5'h01;
            sample = (s_q.edges[0] == s_q.mode[0]);
            setup = !sample;
            if (s_q.edges == spi_pkg::LAST_EDGE) done = 1'b1;
          end else begin
            s_d.div = s_q.div + 8'h01;
          end
        end else if (s_q.ss_f) begin
          s_d.ph = spi_pkg::PH_IDLE;
        end else if (s_d.sck_f != s_q.sck_f) begin
          leading = (s_d.sck_f != s_q.mode[1]);
          sample = (leading == !s_q.mode[0]);
          setup = !sample;
          if (sample) begin
            s_d.bits = s_q.bits + 3'h1;
            if (s_q.bits == spi_pkg::LAST_BIT) done = 1'b1;
          end
        end
      end
    endcase
    if (sample) s_d.sh = {s_q.sh[6:0], in_bit};
    if (setup) s_d.out = s_q.sh[7];

    // Byte end: store received byte, refill shifter from the transmit buffer when buffered and full
    if (done) begin
      s_d.ph = spi_pkg::PH_IDLE;
      byte_in = s_d.sh;
      if (!s_q.buffer_enable) begin
        s_d.rx_second = byte_in;
        s_d.done_flag = 1'b1;
      end else begin
        if (!s_d.rx_second_valid) begin
          s_d.rx_second = byte_in;
          s_d.rx_second_valid = 1'b1;
        end else if (!s_d.rx_first_valid) begin
          s_d.rx_first = byte_in;
          s_d.rx_first_valid = 1'b1;
        end else if (s_q.tx_full) begin
          s_d.rx_overflow_flag = 1'b1;
        end else begin
          s_d.overflow_pending = 1'b1;
        end
        s_d.rx_complete_flag = 1'b1;
        if (s_q.tx_full) begin
          s_d.sh = s_q.tx_buf;
          s_d.tx_full = 1'b0;
          s_d.data_empty_flag = 1'b1;
          start = s_q.master;
        end else begin
          s_d.tx_complete_flag = 1'b1;
          s_d.data_empty_flag = 1'b1;
        end
      end
    end

    // Data register write
    if (WR && ADDR == spi_pkg::ADDR_DATA) begin
      s_d.data_empty_flag = 1'b0;
      if (!s_q.buffer_enable) begin
        if (s_q.ph == spi_pkg::PH_SHIFT) begin
          s_d.write_collision_flag = 1'b1;
        end else begin
          s_d.sh = WDATA;
          start = s_q.master;
        end
      end else begin
        direct = s_q.wait_for_receive && s_q.enable && s_q.ss_f &&
                 s_d.ph == spi_pkg::PH_IDLE && !s_d.tx_full;
        if (direct) begin
          s_d.sh = WDATA;
          start = s_q.master;
        end else if (!s_d.tx_full) begin
          s_d.tx_buf = WDATA;
          s_d.tx_full = 1'b1;
          if (s_d.ph == spi_pkg::PH_IDLE) start = s_q.master;
        end
      end
    end

    // Transfer start
    if (start && s_q.enable) begin
      s_d.ph = spi_pkg::PH_SHIFT;
      s_d.div = 8'h00;
      s_d.edges = 5'h00;
      s_d.bits = 3'h0;
      if (!s_q.mode[0]) s_d.out = s_d.sh[7];
      if (s_q.overflow_pending) begin
        s_d.rx_overflow_flag = 1'b1;
        s_d.overflow_pending = 1'b0;
      end
    end

    // Select pulled low while master
    if (s_q.enable && s_q.master && !s_q.ss_f && !s_q.slave_select_disable) begin
      s_d.master = 1'b0;
      s_d.ph = spi_pkg::PH_IDLE;
      if (s_q.buffer_enable) s_d.select_trigger_flag = 1'b1;
      else s_d.done_flag = 1'b1;
    end
    if (!s_d.enable) s_d.ph = spi_pkg::PH_IDLE;

    // Pin drivers
    s_d.sck_oe = s_d.enable && s_d.master;
    s_d.mosi_oe = s_d.enable && s_d.master;
    s_d.miso_oe = s_d.enable && !s_d.master && !s_d.ss_f;

    // Interrupt request
    if (s_d.buffer_enable) begin
      s_d.irq = (s_d.rx_complete_irq_enable && s_d.rx_complete_flag) ||
                (s_d.tx_complete_irq_enable && s_d.tx_complete_flag) ||
                (s_d.data_empty_irq_enable && s_d.data_empty_flag) ||
                (s_d.select_trigger_irq_enable && s_d.select_trigger_flag);
    end else begin
      s_d.irq = s_d.single_irq_enable && s_d.done_flag;
    end

    // Read data, one cycle after the strobe
    s_d.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        spi_pkg::ADDR_CTRL_A: begin
          s_d.rdata[spi_pkg::CA_ENABLE] = s_q.enable;
          s_d.rdata[spi_pkg::CA_MASTER] = s_q.master;
        end
        spi_pkg::ADDR_CTRL_B: begin
          s_d.rdata[spi_pkg::CB_BUFFER_ENABLE] = s_q.buffer_enable;
          s_d.rdata[spi_pkg::CB_WAIT_FOR_RECEIVE] = s_q.wait_for_receive;
          s_d.rdata[spi_pkg::CB_SLAVE_SELECT_DISABLE] = s_q.slave_select_disable;
          s_d.rdata[spi_pkg::CB_MODE_LO +: 2] = s_q.mode;
        end
        spi_pkg::ADDR_IRQ_EN: begin
          s_d.rdata[spi_pkg::IE_RX_COMPLETE] = s_q.buffer_enable && s_q.rx_complete_irq_enable;
          s_d.rdata[spi_pkg::IE_TX_COMPLETE] = s_q.buffer_enable && s_q.tx_complete_irq_enable;
          s_d.rdata[spi_pkg::IE_DATA_EMPTY] = s_q.buffer_enable && s_q.data_empty_irq_enable;
          s_d.rdata[spi_pkg::IE_SELECT_TRIGGER] = s_q.buffer_enable && s_q.select_trigger_irq_enable;
          s_d.rdata[spi_pkg::IE_SINGLE] = s_q.single_irq_enable;
        end
        spi_pkg::ADDR_FLAGS: begin
          if (s_q.buffer_enable) begin
            s_d.rdata[spi_pkg::FL_RX_COMPLETE] = s_q.rx_complete_flag;
            s_d.rdata[spi_pkg::FL_TX_COMPLETE] = s_q.tx_complete_flag;
            s_d.rdata[spi_pkg::FL_DATA_EMPTY] = s_q.data_empty_flag;
            s_d.rdata[spi_pkg::FL_SELECT_TRIGGER] = s_q.select_trigger_flag;
            s_d.rdata[spi_pkg::FL_RX_OVERFLOW] = s_q.rx_overflow_flag;
          end else begin
            s_d.rdata[spi_pkg::FL_RX_COMPLETE] = s_q.done_flag;
            s_d.rdata[spi_pkg::FL_TX_COMPLETE] = s_q.write_collision_flag;
          end
        end
        spi_pkg::ADDR_DATA: s_d.rdata = s_q.rx_second;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '0;
      s_q.ss_s <= 3'h7;
      s_q.ss_f <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign RDATA = s_q.rdata;
  assign IRQ = s_q.irq;
  assign SCK_O = s_q.sck;
  assign SCK_OE = s_q.sck_oe;
  assign MOSI_O = s_q.out;
  assign MOSI_OE = s_q.mosi_oe;
  assign MISO_O = s_q.out;
  assign MISO_OE = s_q.miso_oe;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  a_unbuf_irq_gate: assert property (
    !s_q.buffer_enable |-> (IRQ == (s_q.single_irq_enable && s_q.done_flag)))
    else $error("unbuffered interrupt not gated by done flag");
  a_enable_read_zero: assert property (
    (RD && ADDR == spi_pkg::ADDR_IRQ_EN && !s_q.buffer_enable) |=> (RDATA[7:4] == 4'h0))
    else $error("per-source enables visible in unbuffered mode");
  a_data_write_clears: assert property (
    (WR && ADDR == spi_pkg::ADDR_DATA) |=> !s_q.data_empty_flag)
    else $error("data write left data empty flag set");
  a_sck_idle_level: assert property (
    (s_q.ph == spi_pkg::PH_IDLE && $past(s_q.ph) == spi_pkg::PH_IDLE && s_q.master &&
     $stable(s_q.mode)) |-> (SCK_O == s_q.mode[1]))
    else $error("shift clock idle level wrong");
  a_collision_set: assert property (
    (WR && ADDR == spi_pkg::ADDR_DATA && !s_q.buffer_enable && s_q.ph == spi_pkg::PH_SHIFT)
    |=> s_q.write_collision_flag)
    else $error("write collision not flagged");
  a_ovf_unbuf_zero: assert property (
    (RD && ADDR == spi_pkg::ADDR_FLAGS && !s_q.buffer_enable) |=> (RDATA[0] == 1'b0))
    else $error("overflow visible in unbuffered mode");
  a_master_drop: assert property (
    (s_q.enable && s_q.master && !s_q.ss_f && !s_q.slave_select_disable)
    |=> (!s_q.master && (s_q.select_trigger_flag || s_q.done_flag)))
    else $error("select low did not end master operation");
  a_ssd_keeps_master: assert property (
    (s_q.enable && s_q.master && s_q.slave_select_disable && !WR) |=> s_q.master)
    else $error("master lost with select disabled");
  a_txc_after_done: assert property (
    (done && s_q.buffer_enable && !s_q.tx_full) |=> s_q.tx_complete_flag)
    else $error("transfer complete not set");
  a_rx_read_order: assert property (
    (RD && ADDR == spi_pkg::ADDR_DATA && s_q.buffer_enable) |=> (RDATA == $past(s_q.rx_second)))
    else $error("data read returned wrong entry");

  c_master_byte: cover property (done && s_q.master);
  c_overflow: cover property (!s_q.rx_overflow_flag ##1 s_q.rx_overflow_flag);
  c_select_trigger: cover property (!s_q.select_trigger_flag ##1 s_q.select_trigger_flag);
  c_collision: cover property (!s_q.write_collision_flag ##1 s_q.write_collision_flag);

endmodule : spi_buffered_control_status

`default_nettype wire

// ===== spi_buffered_control_status_tb.sv
// Self-checking testbench of the buffered SPI unit
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t: %h not %h", $time, g, e); end end

module spi_buffered_control_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic IRQ_ACK = 1'b0;
  logic SCK_I = 1'b0;
  logic MOSI_I = 1'b0;
  logic SS_N = 1'b1;
  logic [7:0] RDATA;
  logic IRQ, SCK_O, MOSI_O, MISO_I;
  logic SCK_OE, MOSI_OE, MISO_OE;
  logic [1:0] pmode = 2'h0;
  logic [7:0] ptx = 8'h00;
  logic pload = 1'b0;
  logic [7:0] prx, d, r, a;
  int pframes, f0, err_count = 0, num_checks = 0;

  always #10 CORE_CLK = ~CORE_CLK;

  spi_buffered_control_status u_dut (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .IRQ_ACK(IRQ_ACK), .SCK_I(SCK_I), .SCK_O(SCK_O),
    .SCK_OE(SCK_OE), .MOSI_I(MOSI_I), .MOSI_O(MOSI_O), .MOSI_OE(MOSI_OE), .MISO_I(MISO_I), .MISO_O(),
    .MISO_OE(MISO_OE),
    .SS_N(SS_N));
  spi_peer_model u_peer (.sck(SCK_O), .mosi(MOSI_O), .mode(pmode), .tx_byte(ptx), .load(pload),
    .miso(MISO_I), .rx_byte(prx), .frames(pframes));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic logic exp_idle(input logic [1:0] m);
    return m[1]; // Falling leading edge idles high
  endfunction : exp_idle

  task automatic wr(input logic [2:0] ad, input logic [7:0] dt);
    @(posedge CORE_CLK);
    ADDR <= ad;
    WDATA <= dt;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] ad, output logic [7:0] dt);
    @(posedge CORE_CLK);
    ADDR <= ad;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1;
    dt = RDATA;
  endtask : rd

  task automatic peer_load(input logic [7:0] b);
    @(posedge CORE_CLK);
    ptx <= b;
    pload <= 1'b1;
    @(posedge CORE_CLK);
    pload <= 1'b0;
  endtask : peer_load

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic wait_irq();
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge CORE_CLK);
      if (IRQ === 1'b1) break;
    end
    if (i == 400) begin
      err_count++;
      $display("wrong value at %0t: interrupt timeout", $time);
      finish_test();
    end
  endtask : wait_irq

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    r = 8'h50;
    repeat (4) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    // Reset values, unmapped place, masked enables
    for (int k = 1; k < 5; k++) begin
      rd(3'(k), d);
      `CHK(d, spi_pkg::REG_RESET)
    end
    rd(3'h7, d);
    `CHK(d, 8'h00)
    wr(spi_pkg::ADDR_IRQ_EN, 8'hf1);
    rd(spi_pkg::ADDR_IRQ_EN, d);
    `CHK(d, 8'h01)
    $display("test reset done");
    // Unbuffered master in every mode, with a collision
    for (int m = 0; m < 4; m++) begin
      wr(spi_pkg::ADDR_CTRL_B, {6'h00, 2'(m)});
      pmode = 2'(m);
      wr(spi_pkg::ADDR_CTRL_A, 8'h21);
      repeat (4) @(posedge CORE_CLK);
      `CHK(SCK_O, exp_idle(2'(m)))
      r = lfsr(r);
      a = r;
      r = lfsr(r);
      peer_load(r);
      wr(spi_pkg::ADDR_DATA, a);
      wr(spi_pkg::ADDR_DATA, ~a);
      wait_irq();
      `CHK(prx, a)
      rd(spi_pkg::ADDR_FLAGS, d);
      `CHK(d, 8'hc0)
      rd(spi_pkg::ADDR_DATA, d);
      `CHK(d, r)
      rd(spi_pkg::ADDR_FLAGS, d);
      `CHK(d, 8'h00)
      `CHK(IRQ, 1'b0)
    end
    $display("test unbuffered done");
    // Buffered, without and with wait for receive
    pmode = 2'h0;
    for (int w = 0; w < 2; w++) begin
      wr(spi_pkg::ADDR_CTRL_B, {1'b1, 1'(w), 6'h00});
      wr(spi_pkg::ADDR_IRQ_EN, 8'h40);
      r = lfsr(r);
      peer_load(r);
      f0 = pframes;
      wr(spi_pkg::ADDR_DATA, ~r);
      rd(spi_pkg::ADDR_FLAGS, d);
      `CHK(d[5], 1'b0)
      wait_irq();
      `CHK(prx, ~r)
      `CHK(pframes - f0, 2 - w)
      rd(spi_pkg::ADDR_FLAGS, d);
      `CHK(d, 8'he0)
      for (int k = 0; k < 2 - w; k++) begin
        rd(spi_pkg::ADDR_DATA, d);
        `CHK(d, r + 8'(k))
      end
      rd(spi_pkg::ADDR_FLAGS, d);
      `CHK(d, 8'h60)
      wr(spi_pkg::ADDR_FLAGS, 8'h40);
      rd(spi_pkg::ADDR_FLAGS, d);
      `CHK(d, 8'h20)
    end
    // Three bytes unread, then a new transfer
    repeat (3) begin
      wr(spi_pkg::ADDR_DATA, r);
      wait_irq();
      wr(spi_pkg::ADDR_FLAGS, 8'h40);
    end
    rd(spi_pkg::ADDR_FLAGS, d);
    `CHK(d[0], 1'b0)
    wr(spi_pkg::ADDR_DATA, r);
    repeat (8) @(posedge CORE_CLK);
    rd(spi_pkg::ADDR_FLAGS, d);
    `CHK(d[0], 1'b1)
    rd(spi_pkg::ADDR_DATA, d);
    rd(spi_pkg::ADDR_FLAGS, d);
    `CHK(d[0], 1'b0)
    wait_irq();
    $display("test buffered done");
    // Select pulled low while master
    for (int s = 0; s < 3; s++) begin
      wr(spi_pkg::ADDR_CTRL_B, s == 0 ? 8'h00 : {1'b1, 4'h0, 1'(s - 1), 2'h0});
      wr(spi_pkg::ADDR_IRQ_EN, s == 0 ? 8'h01 : 8'h10);
      wr(spi_pkg::ADDR_CTRL_A, 8'h21);
      SS_N <= 1'b0;
      repeat (8) @(posedge CORE_CLK);
      rd(spi_pkg::ADDR_CTRL_A, d);
      `CHK(d, s == 2 ? 8'h21 : 8'h01)
      `CHK(IRQ, s != 2)
      `CHK(SCK_OE, s == 2)
      `CHK(MOSI_OE, s == 2)
      `CHK(MISO_OE, s != 2)
      rd(spi_pkg::ADDR_FLAGS, d);
      `CHK(s == 0 ? d[7] : d[4], s != 2)
      SS_N <= 1'b1;
      @(posedge CORE_CLK);
      IRQ_ACK <= 1'b1;
      @(posedge CORE_CLK);
      IRQ_ACK <= 1'b0;
      wr(spi_pkg::ADDR_FLAGS, 8'h10);
      rd(spi_pkg::ADDR_FLAGS, d);
      `CHK(s == 0 ? d[7] : d[4], 1'b0)
    end
    $display("test select done");
    // Unbuffered slave receives one byte on the link clock
    wr(spi_pkg::ADDR_CTRL_B, 8'h00);
    wr(spi_pkg::ADDR_CTRL_A, 8'h01);
    r = lfsr(r);
    SS_N <= 1'b0;
    repeat (6) @(posedge CORE_CLK);
    for (int i = 7; i >= 0; i--) begin
      MOSI_I <= r[i];
      repeat (4) @(posedge CORE_CLK);
      SCK_I <= 1'b1; // Link clock high half, 80 ns
      repeat (4) @(posedge CORE_CLK);
      SCK_I <= 1'b0;
    end
    MOSI_I <= ~r[0];
    repeat (8) @(posedge CORE_CLK);
    SS_N <= 1'b1;
    rd(spi_pkg::ADDR_FLAGS, d);
    `CHK(d, 8'h80)
    rd(spi_pkg::ADDR_DATA, d);
    `CHK(d, r)
    $display("test slave done");
    finish_test();
  end
endmodule : spi_buffered_control_status_tb

`default_nettype wire

// ===== spi_peer_model.sv
// SPI slave-side peer model that answers the unit's master transfers
`default_nettype none

module spi_peer_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic [1:0] mode,
  input wire logic [7:0] tx_byte,
  input wire logic load,
  output var logic miso,
  output var logic [7:0] rx_byte,
  output var int frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  logic [7:0] nxt = 8'h00;
  logic [7:0] acc = 8'h00;
  int cnt = 0;

  // Outgoing bit, MSB first
  assign miso = sh[7];

  // Load a start byte; later frames count up from it
  always @(posedge load) begin
    sh = tx_byte;
    nxt = tx_byte + 8'h01;
    cnt = 0;
  end

  // Sample edge rising in modes 0 and 3, falling in 1 and 2
  initial frames = 0;
  always @(sck) begin
    if (sck === (mode == 2'h0 || mode == 2'h3)) begin
      acc = {acc[6:0], mosi};
      cnt++;
      if (cnt == 8) begin
        rx_byte = acc;
        frames++;
        sh = nxt;
        nxt++;
        cnt = 0;
      end
    end else if (cnt > 0) begin
      sh = {sh[6:0], ~sh[0]}; // Setup edge: next bit
    end
  end
endmodule : spi_peer_model

`default_nettype wire

// ===== spi_pkg.sv
// Constants, field positions and state types of the buffered SPI unit
`default_nettype none

package spi_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL_A = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B = 3'h1;
  localparam logic [2:0] ADDR_IRQ_EN = 3'h2;
  localparam logic [2:0] ADDR_FLAGS = 3'h3;
  localparam logic [2:0] ADDR_DATA = 3'h4;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CA_ENABLE = 0;
  localparam int CA_MASTER = 5;
  localparam int CB_BUFFER_ENABLE = 7;
  localparam int CB_WAIT_FOR_RECEIVE = 6;
  localparam int CB_SLAVE_SELECT_DISABLE = 2;
  localparam int CB_MODE_LO = 0;
  localparam int IE_RX_COMPLETE = 7;
  localparam int IE_TX_COMPLETE = 6;
  localparam int IE_DATA_EMPTY = 5;
  localparam int IE_SELECT_TRIGGER = 4;
  localparam int IE_SINGLE = 0;
  localparam int FL_RX_COMPLETE = 7;
  localparam int FL_TX_COMPLETE = 6;
  localparam int FL_DATA_EMPTY = 5;
  localparam int FL_SELECT_TRIGGER = 4;
  localparam int FL_RX_OVERFLOW = 0;

  // ------------------------------------------------------------
  // Reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] LAST_EDGE = 5'h0f;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCK_HALF_NS = 80;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic {
    PH_IDLE = 1'b0,
    PH_SHIFT = 1'b1
  } phase_t;

  typedef struct packed {
    logic enable;
    logic master;
    logic buffer_enable;
    logic wait_for_receive;
    logic slave_select_disable;
    logic [1:0] mode;
    logic rx_complete_irq_enable;
    logic tx_complete_irq_enable;
    logic data_empty_irq_enable;
    logic select_trigger_irq_enable;
    logic single_irq_enable;
    logic rx_complete_flag;
    logic tx_complete_flag;
    logic data_empty_flag;
    logic select_trigger_flag;
    logic rx_overflow_flag;
    logic overflow_pending;
    logic done_flag;
    logic write_collision_flag;
    logic clear_armed;
    phase_t ph;
    logic [7:0] div;
    logic [4:0] edges;
    logic [2:0] bits;
    logic [7:0] sh;
    logic out;
    logic [7:0] rx_first;
    logic [7:0] rx_second;
    logic rx_first_valid;
    logic rx_second_valid;
    logic [7:0] tx_buf;
    logic tx_full;
    logic [2:0] ss_s;
    logic [2:0] sck_s;
    logic [2:0] mosi_s;
    logic [2:0] miso_s;
    logic ss_f;
    logic sck_f;
    logic mosi_f;
    logic miso_f;
    logic sck;
    logic sck_oe;
    logic mosi_oe;
    logic miso_oe;
    logic [7:0] rdata;
    logic irq;
  } state_t;

endpackage : spi_pkg

`default_nettype wire
